// ==== rtl/event_condition_break_unit.sv ====
// Event condition break unit: four bus comparator channels, sequencer and measurement window
//
// Contract
// - Address channel matches when data access address equals compare address.
// - Address channel may compare program counter, before or after execution.
// - Data channel compares data bus with selectable byte, word or longword size.
// - Bus-state channel can be qualified to fire on read only or write only.
// - Counting channel fires only after conditions met the programmed number of times.
// - Four channels; ch1 full, ch2 no count, ch3 and ch4 address only.
// - Channels 1 and 2 break or control measurement; 4 takes its own action, 3 too except in two- and three-stage modes; neither controls measurement.
// - With occurrence counter in use, a channel may only raise a break.
// - Each channel has an action: break, trace halt or trace acquisition.
// - Three-stage mode breaks only after ch3, then ch2, then ch1 match.
// - Two-stage mode breaks only after ch2 then ch1 match.
// - One measurement mode opens on ch2 match and closes on later ch1 match.
// - Opposite measurement mode opens on ch1 match and closes on ch2 match.
// - Combination none: channels 1 to 3 independent, no sequence, no measurement.
// - Measurement restarts on a new start and accumulates, never cleared between periods.
// - A match coinciding with power-on reset counts as not satisfied.
// - Setting change suspends execution at most 52 clocks; no matches meanwhile.
`timescale 1ns/1ps
`default_nettype none
`include "evbrk_defs.svh"

module event_condition_break_unit
    import evbrk_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int PERF_W = 32
)(
    // Clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RESET_N,
    // Observed CPU bus activity
    input  wire bus_obs_t          BUS_OBS,
    // Channel and combination setup from the debug port
    input  wire logic              CFG_CH_WE,
    input  wire logic [1:0]        CFG_CH_SEL,
    input  wire chan_cfg_t         CFG_CH,
    input  wire logic              CFG_MODE_WE,
    input  wire comb_mode_t        CFG_MODE,
    // Actions and status
    output logic                   BREAK_REQ,
    output logic                   TRACE_HALT,
    output logic                   TRACE_ACQ,
    output logic                   CPU_SUSPEND,
    output logic                   PERF_WINDOW,
    output logic [PERF_W-1:0]      PERF_CYCLES,
    output logic [NUM_CH-1:0]      CH_EVENT,
    output logic [1:0]             SEQ_STAGE
);

    chan_cfg_t                  cfg_q [NUM_CH];
    comb_mode_t                 mode_q;
    logic [`EVB_UPD_HOLD_W-1:0] hold_q;
    logic                       ready_q;
    logic [15:0]                cnt_q;
    logic [NUM_CH-1:0]          raw;
    logic [NUM_CH-1:0]          ev;
    logic                       cfg_wr;
    logic                       armed;
    logic                       ch1_perf_ok;
    logic                       seq_mode;
    logic                       perf_mode;
    logic                       seq_brk;
    logic                       start_ev;
    logic                       end_ev;
    logic [NUM_CH-1:0]          indep;

    assign cfg_wr = CFG_CH_WE | CFG_MODE_WE;
    // Comparators are blind while settings settle and in the first cycle after reset
    assign armed  = ready_q & ~CPU_SUSPEND;

    // Settings store; the hold keeps the CPU still so no half-written channel can fire
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int i = 0; i < NUM_CH; i++)
                cfg_q[i] <= '0;
            mode_q <= COMB_NONE;
        end
        else
        begin
            if (CFG_CH_WE)
                cfg_q[CFG_CH_SEL] <= CFG_CH;
            if (CFG_MODE_WE)
                mode_q <= CFG_MODE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            hold_q <= '0;
        else if (cfg_wr)
            hold_q <= `EVB_UPD_HOLD_W'(`EVB_UPD_HOLD_CLKS);
        else if (hold_q != '0)
            hold_q <= hold_q - 1'b1;
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ready_q     <= 1'b0;
            CPU_SUSPEND <= 1'b0;
        end
        else
        begin
            ready_q     <= 1'b1;
            CPU_SUSPEND <= cfg_wr | (hold_q > `EVB_UPD_HOLD_W'(1));
        end
    end

    // Per-channel comparators; capabilities narrow with the channel index
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        localparam bit HAS_BUS = (g < 2);
        logic a_hit;
        logic d_hit;
        logic w_hit;
        logic any;
        always_comb
        begin
            case (cfg_q[g].addr_src)
                ASRC_DATA:    a_hit = BUS_OBS.acc_valid && BUS_OBS.acc_addr == cfg_q[g].addr;
                ASRC_PC_PRE:  a_hit = BUS_OBS.pc_pre_valid && BUS_OBS.pc_pre == cfg_q[g].addr;
                ASRC_PC_POST: a_hit = BUS_OBS.pc_post_valid && BUS_OBS.pc_post == cfg_q[g].addr;
                default:      a_hit = 1'b0;
            endcase
            case (cfg_q[g].data_size)
                `EVB_SIZE_BYTE: d_hit = BUS_OBS.acc_data[7:0] == cfg_q[g].data[7:0];
                `EVB_SIZE_WORD: d_hit = BUS_OBS.acc_data[15:0] == cfg_q[g].data[15:0];
                default:        d_hit = BUS_OBS.acc_data == cfg_q[g].data;
            endcase
            d_hit = d_hit && BUS_OBS.acc_valid && BUS_OBS.acc_size == cfg_q[g].data_size;
            w_hit = BUS_OBS.acc_valid && BUS_OBS.acc_write == cfg_q[g].rw_write;
            any   = cfg_q[g].addr_en | (HAS_BUS & (cfg_q[g].data_en | cfg_q[g].rw_en));
        end
        assign raw[g] = cfg_q[g].enable & any & armed
                      & (~cfg_q[g].addr_en | a_hit)
                      & (~(HAS_BUS & cfg_q[g].data_en) | d_hit)
                      & (~(HAS_BUS & cfg_q[g].rw_en) | w_hit);
    end

    // Occurrence counter exists on channel 1 only; a count of zero acts as one
    logic cnt_on;
    logic cnt_done;
    assign cnt_on   = cfg_q[0].count_en;
    assign cnt_done = (cnt_q + 16'h0001 >= cfg_q[0].count);
    always_comb
    begin
        ev    = raw;
        ev[0] = raw[0] & (~cnt_on | cnt_done);
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            cnt_q <= '0;
        else if (cfg_wr)
            cnt_q <= '0;
        else if (raw[0] && cnt_on)
            cnt_q <= cnt_done ? 16'h0000 : cnt_q + 16'h0001;
    end

    // A counting channel 1 never steers measurement
    assign ch1_perf_ok = ~cnt_on;
    assign seq_mode    = (mode_q == COMB_SEQ321) || (mode_q == COMB_SEQ21);
    assign perf_mode   = (mode_q == COMB_PERF21) || (mode_q == COMB_PERF12);
    assign start_ev    = (mode_q == COMB_PERF21) ? ev[1] : (ev[0] & ch1_perf_ok);
    assign end_ev      = (mode_q == COMB_PERF21) ? (ev[0] & ch1_perf_ok) : ev[1];
    assign seq_brk     = seq_mode && SEQ_STAGE == `EVB_STAGE_CH1 && ev[0];

    // Channels that act on their own action
    always_comb
    begin
        indep = ev;
        if (seq_mode)
            indep[2:0] = 3'h0;
        else if (perf_mode)
            indep[1:0] = {1'b0, ev[0] & ~ch1_perf_ok};
    end

    // Sequencer: one stage per cycle, so a late stage cannot complete before an early one
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            SEQ_STAGE <= `EVB_STAGE_CH3;
        else if (cfg_wr)
            SEQ_STAGE <= (CFG_MODE_WE && CFG_MODE == COMB_SEQ21) ||
                         (!CFG_MODE_WE && mode_q == COMB_SEQ21)
                         ? `EVB_STAGE_CH2 : `EVB_STAGE_CH3;
        else if (!seq_mode)
            SEQ_STAGE <= `EVB_STAGE_CH3;
        else
        begin
            case (SEQ_STAGE)
                `EVB_STAGE_CH3:
                    if (ev[2])
                        SEQ_STAGE <= `EVB_STAGE_CH2;
                `EVB_STAGE_CH2:
                    if (ev[1])
                        SEQ_STAGE <= `EVB_STAGE_CH1;
                `EVB_STAGE_CH1:
                    if (ev[0])
                        SEQ_STAGE <= (mode_q == COMB_SEQ21) ? `EVB_STAGE_CH2
                                                             : `EVB_STAGE_CH3;
                default:
                    SEQ_STAGE <= `EVB_STAGE_CH3;
            endcase
        end
    end

    // Measurement window and its accumulated cycle count
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            PERF_WINDOW <= 1'b0;
        else if (!perf_mode)
            PERF_WINDOW <= 1'b0;
        else if (!PERF_WINDOW && start_ev)
            PERF_WINDOW <= 1'b1;
        else if (PERF_WINDOW && end_ev)
            PERF_WINDOW <= 1'b0;
    end

    // Only reset clears the total, so separate periods add up
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            PERF_CYCLES <= '0;
        else if (PERF_WINDOW)
            PERF_CYCLES <= PERF_CYCLES + 1'b1;
    end

    // Action outputs; independent channels follow their own action, except that a counting channel 1 always breaks
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            BREAK_REQ  <= 1'b0;
            TRACE_HALT <= 1'b0;
            TRACE_ACQ  <= 1'b0;
            CH_EVENT   <= '0;
        end
        else
        begin
            BREAK_REQ  <= seq_brk;
            TRACE_HALT <= 1'b0;
            TRACE_ACQ  <= 1'b0;
            CH_EVENT   <= ev;
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (indep[i])
                begin
                    // Counting channel 1 is forced to break
                    if (cfg_q[i].action == ACT_BREAK || (i == 0 && cnt_on))
                        BREAK_REQ <= 1'b1;
                    else if (cfg_q[i].action == ACT_TRC_HALT)
                        TRACE_HALT <= 1'b1;
                    else
                        TRACE_ACQ <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    AST_HOLD_AFTER_WRITE: assert property (cfg_wr |=> CPU_SUSPEND [*8])
        else $error("execution not held after setting change");
    AST_QUIET_DURING_HOLD: assert property (CPU_SUSPEND |-> ev == '0)
        else $error("channel fired while settings settle");
    AST_NO_EVENT_AT_RESET: assert property (!ready_q |-> raw == '0)
        else $error("match counted at reset");
    AST_SEQ_ORDER: assert property (seq_brk |-> $past(SEQ_STAGE) != `EVB_STAGE_CH3
        || $past(cfg_wr)) else $error("sequence break without earlier stage");
    AST_SEQ_BREAK_OUT: assert property (seq_brk |=> BREAK_REQ)
        else $error("completed sequence gave no break");
    AST_SEQ_CLEAR: assert property (cfg_wr |=> SEQ_STAGE != `EVB_STAGE_CH1)
        else $error("sequencer kept progress over setting change");
    AST_PERF_OPEN: assert property (perf_mode && !PERF_WINDOW && start_ev |=>
        PERF_WINDOW) else $error("measurement did not open");
    AST_PERF_CLOSE: assert property (perf_mode && PERF_WINDOW && end_ev && !cfg_wr |=>
        !PERF_WINDOW) else $error("measurement did not close");
    AST_PERF_ACCUM: assert property (PERF_WINDOW |=>
        PERF_CYCLES == $past(PERF_CYCLES) + 1'b1) else $error("measurement total not added");
    AST_NONE_NO_PERF: assert property (mode_q == COMB_NONE |=> !PERF_WINDOW)
        else $error("measurement active with no combination");
    AST_COUNT_GATE: assert property (ev[0] && cnt_on |-> cnt_done)
        else $error("counting channel fired early");

endmodule // event_condition_break_unit
`default_nettype wire

// ==== rtl/evbrk_defs.svh ====
// Offset-free constants of the event condition break unit: reset values and timing counts
`ifndef EVBRK_DEFS_SVH
`define EVBRK_DEFS_SVH
// Bus clocks that execution is held while channel or combination settings change
`define EVB_UPD_HOLD_CLKS    52
`define EVB_UPD_HOLD_W       6
// Count value that means a single occurrence
`define EVB_CNT_ONCE         1
// Sequencer stage indices
`define EVB_STAGE_CH3        2'h0
`define EVB_STAGE_CH2        2'h1
`define EVB_STAGE_CH1        2'h2
// Access sizes as carried on the observed bus
`define EVB_SIZE_BYTE        2'h0
`define EVB_SIZE_WORD        2'h1
`define EVB_SIZE_LONG        2'h2
`endif

// ==== rtl/evbrk_pkg.sv ====
// Types of the event condition break unit
package evbrk_pkg;
    typedef enum logic [1:0] {ASRC_DATA = 2'b00, ASRC_PC_PRE = 2'b01, ASRC_PC_POST = 2'b10}
        addr_src_t;
    typedef enum logic [1:0] {ACT_BREAK = 2'b00, ACT_TRC_HALT = 2'b01, ACT_TRC_ACQ = 2'b10}
        action_t;
    typedef enum logic [2:0] {COMB_NONE = 3'b000, COMB_SEQ321 = 3'b001, COMB_SEQ21 = 3'b010,
        COMB_PERF21 = 3'b011, COMB_PERF12 = 3'b100} comb_mode_t;
    typedef struct packed {
        logic        acc_valid;
        logic        acc_write;
        logic [1:0]  acc_size;
        logic [31:0] acc_addr;
        logic [31:0] acc_data;
        logic        pc_pre_valid;
        logic [31:0] pc_pre;
        logic        pc_post_valid;
        logic [31:0] pc_post;
    } bus_obs_t;
    typedef struct packed {
        logic        enable;
        logic        addr_en;
        addr_src_t   addr_src;
        logic [31:0] addr;
        logic        data_en;
        logic [1:0]  data_size;
        logic [31:0] data;
        logic        rw_en;
        logic        rw_write;
        logic        count_en;
        logic [15:0] count;
        action_t     action;
    } chan_cfg_t;
endpackage

// ==== verification/emu_model.sv ====
// Debug-port partner model: drives channel and combination setup pulses
`timescale 1ns/1ps
`default_nettype none
`include "evbrk_defs.svh"
module emu_model
    import evbrk_pkg::*;
(
    // Clock
    input  wire logic       CORE_CLK,
    // Setup port
    output logic            CFG_CH_WE,
    output logic [1:0]      CFG_CH_SEL,
    output chan_cfg_t       CFG_CH,
    output logic            CFG_MODE_WE,
    output comb_mode_t      CFG_MODE
);
    comb_mode_t cur_mode;
    initial
    begin
        CFG_CH_WE   = 1'b0;
        CFG_CH_SEL  = 2'h0;
        CFG_CH      = '0;
        CFG_MODE_WE = 1'b0;
        CFG_MODE    = COMB_NONE;
        cur_mode    = COMB_NONE;
    end
    task automatic set_ch(input logic [1:0] sel, input chan_cfg_t c);
        chan_cfg_t v;
        v = c;
        if (sel == 2'h0 && (cur_mode == COMB_PERF21 || cur_mode == COMB_PERF12))
            v.count = 16'(`EVB_CNT_ONCE);
        @(posedge CORE_CLK);
        CFG_CH_WE  <= 1'b1;
        CFG_CH_SEL <= sel;
        CFG_CH     <= v;
        @(posedge CORE_CLK);
        // Released lines show garbage, never the last setting
        CFG_CH_WE  <= 1'b0;
        CFG_CH_SEL <= ~sel;
        CFG_CH     <= ~v;
    endtask
    task automatic set_mode(input comb_mode_t m);
        @(posedge CORE_CLK);
        CFG_MODE_WE <= 1'b1;
        CFG_MODE    <= m;
        cur_mode    <= m;
        @(posedge CORE_CLK);
        CFG_MODE_WE <= 1'b0;
        CFG_MODE    <= comb_mode_t'(~m);
    endtask
endmodule // emu_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Testbench of the event condition break unit
`timescale 1ns/1ps
`default_nettype none
`include "evbrk_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp=%0h got=%0h", n, e, g); end end
module testbench
    import evbrk_pkg::*;
;
    typedef struct {
        logic [1:0] sel;
        chan_cfg_t  c;
        bus_obs_t   b;
        logic [3:0] ev;
        logic [2:0] act;
    } row_t;
    logic        clk, rst_n, ch_we, mode_we, brk, halt, acq, susp, win;
    logic [1:0]  ch_sel, stage;
    logic [3:0]  ev, ev_s;
    logic [2:0]  act_s;
    logic [31:0] cyc, susp_n, win_n, first;
    bus_obs_t    obs, b;
    chan_cfg_t   ch_cfg, c;
    comb_mode_t  mode;
    int          miscompares, total_checks, i;
    row_t        rows[10];
    event_condition_break_unit dut (
        .CORE_CLK    (clk),
        .RESET_N     (rst_n),
        .BUS_OBS     (obs),
        .CFG_CH_WE   (ch_we),
        .CFG_CH_SEL  (ch_sel),
        .CFG_CH      (ch_cfg),
        .CFG_MODE_WE (mode_we),
        .CFG_MODE    (mode),
        .BREAK_REQ   (brk),
        .TRACE_HALT  (halt),
        .TRACE_ACQ   (acq),
        .CPU_SUSPEND (susp),
        .PERF_WINDOW (win),
        .PERF_CYCLES (cyc),
        .CH_EVENT    (ev),
        .SEQ_STAGE   (stage)
    );
    emu_model emu (
        .CORE_CLK    (clk),
        .CFG_CH_WE   (ch_we),
        .CFG_CH_SEL  (ch_sel),
        .CFG_CH      (ch_cfg),
        .CFG_MODE_WE (mode_we),
        .CFG_MODE    (mode)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Pulses are one cycle wide, so they are gathered rather than sampled once
    always @(posedge clk)
    begin
        ev_s   <= ev_s | ev;
        act_s  <= act_s | {acq, halt, brk};
        susp_n <= susp_n + {31'h0, susp};
        win_n  <= win_n + {31'h0, win};
    end
    function automatic chan_cfg_t mk(logic [2:0] e, addr_src_t s, logic [31:0] a,
                                     logic [1:0] z, logic [31:0] d, logic w, action_t t);
        chan_cfg_t r;
        r = '0;
        r.enable = 1'b1;
        {r.rw_en, r.data_en, r.addr_en} = e;
        r.addr_src = s;
        r.addr = a;
        r.data_size = z;
        r.data = d;
        r.rw_write = w;
        r.action = t;
        return r;
    endfunction
    function automatic bus_obs_t ob(logic [1:0] k, logic [31:0] a, logic [1:0] z,
                                    logic [31:0] d, logic w);
        bus_obs_t r;
        r = '0;
        r.acc_valid = (k == 2'h0);
        r.acc_write = w;
        r.acc_size = z;
        r.acc_addr = a;
        r.acc_data = d;
        r.pc_pre_valid = (k == 2'h1);
        r.pc_pre = a;
        r.pc_post_valid = (k == 2'h2);
        r.pc_post = a;
        return r;
    endfunction
    task automatic test_done();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic clr();
        ev_s = '0;
        act_s = '0;
        susp_n = '0;
    endtask
    // Wait out the setting hold under a bound
    task automatic settle();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        while (susp !== 1'b0 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 60)
        begin
            miscompares++;
            test_done();
        end
    endtask
    task automatic wch(input logic [1:0] s, input chan_cfg_t v);
        emu.set_ch(s, v);
        settle();
        clr();
    endtask
    task automatic wmd(input comb_mode_t m);
        emu.set_mode(m);
        settle();
        clr();
    endtask
    task automatic hit(input bus_obs_t v);
        @(posedge clk);
        obs <= v;
        @(posedge clk);
        obs <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic seq(input logic [31:0] a, input logic [1:0] st, input logic [2:0] bk);
        hit(ob(2'h2, a, 2'h2, 32'h0, 1'b0));
        if (st != 2'h3)
            `CHK("seq_stage", st, stage)
        `CHK("seq_break", bk, act_s)
        clr();
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial
    begin
        rst_n = 1'b0;
        obs = '0;
        miscompares = 0;
        total_checks = 0;
        win_n = '0;
        clr();
        rows[0] = '{2'h0, mk(3'h1, ASRC_DATA, 32'h100, 2'h0, 32'h0, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h100, 2'h2, 32'h0, 1'b0), 4'h1, 3'h1};
        rows[1] = '{2'h1, mk(3'h1, ASRC_PC_PRE, 32'h200, 2'h0, 32'h0, 1'b0, ACT_BREAK),
                    ob(2'h1, 32'h200, 2'h2, 32'h0, 1'b0), 4'h2, 3'h1};
        rows[2] = '{2'h2, mk(3'h1, ASRC_PC_POST, 32'h300, 2'h0, 32'h0, 1'b0, ACT_TRC_HALT),
                    ob(2'h2, 32'h300, 2'h2, 32'h0, 1'b0), 4'h4, 3'h2};
        rows[3] = '{2'h3, mk(3'h3, ASRC_DATA, 32'h400, 2'h2, 32'h77, 1'b0, ACT_TRC_ACQ),
                    ob(2'h0, 32'h400, 2'h2, 32'h11, 1'b0), 4'h8, 3'h4};
        rows[4] = '{2'h0, mk(3'h2, ASRC_DATA, 32'h0, `EVB_SIZE_BYTE, 32'h5A, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h500, `EVB_SIZE_BYTE, 32'h5A, 1'b0), 4'h1, 3'h1};
        rows[5] = '{2'h1, mk(3'h2, ASRC_DATA, 32'h0, `EVB_SIZE_WORD, 32'h1234, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h600, `EVB_SIZE_WORD, 32'h1234, 1'b0), 4'h2, 3'h1};
        rows[6] = '{2'h0, mk(3'h2, ASRC_DATA, 32'h0, 2'h2, 32'hCAFEF00D, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h650, 2'h2, 32'hCAFEF00D, 1'b0), 4'h1, 3'h1};
        rows[7] = '{2'h1, mk(3'h2, ASRC_DATA, 32'h0, `EVB_SIZE_WORD, 32'h1234, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h660, `EVB_SIZE_BYTE, 32'h1234, 1'b0), 4'h0, 3'h0};
        rows[8] = '{2'h1, mk(3'h4, ASRC_DATA, 32'h0, 2'h0, 32'h0, 1'b0, ACT_BREAK),
                    ob(2'h0, 32'h700, 2'h2, 32'h0, 1'b1), 4'h0, 3'h0};
        rows[9] = '{2'h1, mk(3'h4, ASRC_DATA, 32'h0, 2'h0, 32'h0, 1'b1, ACT_BREAK),
                    ob(2'h0, 32'h700, 2'h2, 32'h0, 1'b1), 4'h2, 3'h1};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        for (i = 0; i < 10; i++)
        begin
            wch(rows[i].sel, rows[i].c);
            hit(rows[i].b);
            `CHK("ch_event", rows[i].ev, ev_s)
            `CHK("action", rows[i].act, act_s)
        end
        b = ob(2'h0, 32'hB00, 2'h2, 32'h0, 1'b0);
        // The last row's event and any earlier hold must not leak into the hold count
        clr();
        emu.set_ch(2'h3, mk(3'h1, ASRC_DATA, 32'hB00, 2'h0, 32'h0, 1'b0, ACT_BREAK));
        hit(b);
        settle();
        `CHK("upd_event", 4'h0, ev_s)
        `CHK("upd_hold", `EVB_UPD_HOLD_CLKS, susp_n)
        hit(b);
        `CHK("upd_live", 4'h8, ev_s)
        c = mk(3'h1, ASRC_DATA, 32'hA00, 2'h0, 32'h0, 1'b0, ACT_TRC_ACQ);
        c.count_en = 1'b1;
        c.count = 16'h0003;
        b = ob(2'h0, 32'hA00, 2'h2, 32'h0, 1'b0);
        wch(2'h0, c);
        repeat (2) hit(b);
        `CHK("cnt_early", 4'h0, ev_s)
        hit(b);
        `CHK("cnt_fire", 4'h1, ev_s)
        `CHK("cnt_act", 3'h1, act_s)
        hit(b);
        wch(2'h0, c);
        repeat (2) hit(b);
        `CHK("cnt_clear", 4'h0, ev_s)
        wch(2'h2, mk(3'h1, ASRC_PC_POST, 32'hC30, 2'h0, 32'h0, 1'b0, ACT_BREAK));
        wch(2'h1, mk(3'h1, ASRC_PC_POST, 32'hC20, 2'h0, 32'h0, 1'b0, ACT_BREAK));
        wch(2'h0, mk(3'h1, ASRC_PC_POST, 32'hC10, 2'h0, 32'h0, 1'b0, ACT_BREAK));
        wmd(COMB_SEQ321);
        // Stage events stay several cycles apart
        seq(32'hC10, 2'h0, 3'h0);
        seq(32'hC30, 2'h1, 3'h0);
        seq(32'hC20, 2'h2, 3'h0);
        seq(32'hC10, 2'h0, 3'h1);
        seq(32'hC30, 2'h1, 3'h0);
        wch(2'h2, mk(3'h1, ASRC_PC_POST, 32'hC30, 2'h0, 32'h0, 1'b0, ACT_BREAK));
        `CHK("seq_clear", 2'h0, stage)
        wmd(COMB_SEQ21);
        seq(32'hC10, 2'h1, 3'h0);
        seq(32'hC20, 2'h2, 3'h0);
        seq(32'hC10, 2'h1, 3'h1);
        wmd(COMB_PERF21);
        hit(ob(2'h2, 32'hC20, 2'h2, 32'h0, 1'b0));
        `CHK("win_open", 1'b1, win)
        repeat (8) @(posedge clk);
        hit(ob(2'h2, 32'hC10, 2'h2, 32'h0, 1'b0));
        `CHK("win_close", 1'b0, win)
        `CHK("perf_nobrk", 3'h0, act_s)
        `CHK("perf_cyc", win_n, cyc)
        `CHK("perf_len", 32'h0000000C, cyc)
        first = cyc;
        hit(ob(2'h2, 32'hC20, 2'h2, 32'h0, 1'b0));
        hit(ob(2'h2, 32'hC10, 2'h2, 32'h0, 1'b0));
        `CHK("perf_acc", win_n, cyc)
        `CHK("perf_sum", 32'h00000010, cyc)
        `CHK("perf_grow", 1'b1, cyc > first)
        wmd(COMB_PERF12);
        hit(ob(2'h2, 32'hC10, 2'h2, 32'h0, 1'b0));
        `CHK("win12_open", 1'b1, win)
        hit(ob(2'h2, 32'hC20, 2'h2, 32'h0, 1'b0));
        `CHK("win12_close", 1'b0, win)
        // Counting ch1 in a measurement mode: the emulator forces a single occurrence
        c = mk(3'h1, ASRC_PC_POST, 32'hC10, 2'h0, 32'h0, 1'b0, ACT_TRC_HALT);
        c.count_en = 1'b1;
        c.count = 16'h0005;
        wch(2'h0, c);
        hit(ob(2'h2, 32'hC10, 2'h2, 32'h0, 1'b0));
        `CHK("cnt_perf_ev", 4'h1, ev_s)
        `CHK("cnt_perf_win", 1'b0, win)
        `CHK("cnt_perf_act", 3'h1, act_s)
        hit(ob(2'h2, 32'hC10, 2'h2, 32'h0, 1'b0));
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        win_n = '0;
        `CHK("rst_win", 1'b0, win)
        `CHK("rst_cyc", 32'h0, cyc)
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        clr();
        hit(ob(2'h2, 32'hC30, 2'h2, 32'h0, 1'b0));
        `CHK("rst_cfg", 4'h0, ev_s)
        test_done();
    end
endmodule // testbench
`default_nettype wire
